// *** verification/card_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module card_model
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       inserted,
  input  wire logic [1:0] batt,
  input  wire logic       irq_req,
  input  wire logic       io_mode,
  input  wire logic       io_read_strobe_n,
  input  wire logic       write_enable_n,
  output logic            card_detect_one,
  output logic            card_detect_two,
  output logic            batt_detect_one,
  output logic            batt_detect_two,
  output logic            ready_irq_in,
  output logic            input_ack_n
);
  logic [3:0] busy_ff; // cycles left on a prior write
  assign card_detect_one = !inserted;
  assign card_detect_two = !inserted;
  assign {batt_detect_one, batt_detect_two} = batt;
  // ack only while read strobe is low
  assign input_ack_n = io_read_strobe_n;
  // busy after write, irq in io mode
  assign ready_irq_in = io_mode ? !irq_req : (busy_ff == 4'h0);
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst) busy_ff <= 4'h0;
    else if (!write_enable_n) busy_ff <= 4'h8;
    else if (busy_ff != 4'h0) busy_ff <= busy_ff - 4'h1;
endmodule // card_model
`default_nettype wire

// *** verification/card_socket_control_signals_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module card_socket_control_signals_monitor
(
  input wire logic                      clk,
  input wire logic                      sys_rst,
  input wire card_ctl_pkg::cycle_kind_t cycle_kind [2],
  input wire logic                      cycle_attr [2],
  input wire logic                      byte_even [2],
  input wire logic                      byte_odd [2],
  input wire logic                      io_mode [2],
  input wire logic                      card_detect_one [2],
  input wire logic                      card_detect_two [2],
  input wire logic                      batt_detect_two [2],
  input wire logic                      even_byte_enable_n [2],
  input wire logic                      odd_byte_enable_n [2],
  input wire logic                      io_read_strobe_n [2],
  input wire logic                      io_write_strobe_n [2],
  input wire logic                      output_enable_n [2],
  input wire logic                      attr_select_n [2],
  input wire logic                      card_present [2],
  input wire logic                      combined_audio_out
);
  // cycles since reset; pin checks wait until the sync chain holds post-reset values
  logic [2:0] up_ff;
  logic [2:0] nxt_up;
  always_comb nxt_up = (up_ff == 3'h4) ? up_ff : up_ff + 3'h1;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst) up_ff <= 3'h0;
    else up_ff <= nxt_up;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_req(card_ctl_pkg::cycle_kind_t k);
    card_present[0] && cycle_kind[0] == k;
  endsequence
  sequence s_mix;
    card_present[0] && card_present[1] && io_mode[0] && io_mode[1];
  endsequence
  property p_present;
    up_ff == 3'h4 |-> card_present[0] == !($past(card_detect_one[0], 3) || $past(card_detect_two[0], 3));
  endproperty
  a_present: assert property (p_present) else $error("presence wrong");
  property p_ioread;
    s_req(card_ctl_pkg::cyc_io_read) |=> !io_read_strobe_n[0];
  endproperty
  a_ioread: assert property (p_ioread) else $error("io read strobe missing");
  property p_iowrite;
    s_req(card_ctl_pkg::cyc_io_write) |=> !io_write_strobe_n[0] && io_read_strobe_n[0];
  endproperty
  a_iowrite: assert property (p_iowrite) else $error("io write strobe missing");
  property p_memread;
    s_req(card_ctl_pkg::cyc_mem_read) |=> !output_enable_n[0] && io_read_strobe_n[0];
  endproperty
  a_memread: assert property (p_memread) else $error("output enable missing");
  property p_bytes;
    card_present[0] && cycle_kind[0] != card_ctl_pkg::cyc_none
      |=> even_byte_enable_n[0] == !$past(byte_even[0]) && odd_byte_enable_n[0] == !$past(byte_odd[0]);
  endproperty
  a_bytes: assert property (p_bytes) else $error("byte enables wrong");
  property p_attr;
    card_present[0] && cycle_kind[0] != card_ctl_pkg::cyc_none
      |=> attr_select_n[0] == !($past(cycle_attr[0]) || $past(cycle_kind[0]) >= card_ctl_pkg::cyc_io_read);
  endproperty
  a_attr: assert property (p_attr) else $error("attribute select wrong");
  property p_idle;
    !card_present[0] |=> io_read_strobe_n[0] && io_write_strobe_n[0] && output_enable_n[0]
      && even_byte_enable_n[0] && odd_byte_enable_n[0];
  endproperty
  a_idle: assert property (p_idle) else $error("strobe without card");
  property p_audio;
    up_ff == 3'h4 ##0 s_mix ##1 s_mix
      |-> combined_audio_out == ($past(batt_detect_two[0], 3) ^ $past(batt_detect_two[1], 3));
  endproperty
  a_audio: assert property (p_audio) else $error("audio mix wrong");
endmodule // card_socket_control_signals_monitor
bind card_socket_control_signals card_socket_control_signals_monitor mon
(
  .clk, .sys_rst, .cycle_kind, .cycle_attr, .byte_even, .byte_odd, .io_mode, .card_detect_one,
  .card_detect_two, .batt_detect_two, .even_byte_enable_n, .odd_byte_enable_n, .io_read_strobe_n,
  .io_write_strobe_n, .output_enable_n, .attr_select_n, .card_present, .combined_audio_out
);
`default_nettype wire

// *** verification/test_card_socket_control_signals.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_card_socket_control_signals;
  logic clk, sys_rst, audio;
  card_ctl_pkg::cycle_kind_t kind [2];
  card_ctl_pkg::batt_state_t bst [2];
  logic attr [2], be [2], bo [2], iom [2], ring [2], ins [2], irq [2];
  logic [1:0] batt [2], dst [2];
  wire logic cd1 [2], cd2 [2], b1 [2], b2 [2], rdy [2], ack [2];
  logic ce1 [2], ce2 [2], rd [2], wr [2], oe [2], we [2], rg [2], pres [2], irqn [2], ackd [2], alert [2], ri [2], crdy [2];
  int num_errors, num_checks, cyc, n;
  // rows: ins, batt, io, ring, then {present, batt state, ring, detects}
  logic [15:0] brow [7] = '{16'h1c20, 16'h1828, 16'h1430, 16'h1030, 16'h1734, 16'h1f20, 16'h0c03};
  // rows: kind, even, odd, attr, then {rd, wr, oe, we, ce1, ce2, reg, acked}
  logic [15:0] crow [6] = '{16'h1c75, 16'h26b0, 16'h0ada, 16'h17e0, 16'h0fd0, 16'h00fe};
  card_socket_control_signals uut
  (
    .clk, .sys_rst, .cycle_kind(kind), .cycle_attr(attr), .byte_even(be), .byte_odd(bo), .io_mode(iom),
    .ring_mode(ring), .card_detect_one(cd1), .card_detect_two(cd2), .batt_detect_one(b1), .batt_detect_two(b2),
    .ready_irq_in(rdy), .input_ack_n(ack), .even_byte_enable_n(ce1), .odd_byte_enable_n(ce2),
    .io_read_strobe_n(rd), .io_write_strobe_n(wr), .output_enable_n(oe), .write_enable_n(we),
    .attr_select_n(rg), .card_present(pres), .detect_state(dst), .batt_state(bst), .status_change_alert(alert),
    .ring_indicate_in(ri), .card_ready(crdy), .card_irq_n(irqn), .io_read_acked(ackd), .combined_audio_out(audio)
  );
  for (genvar s = 0; s < 2; s++)
  begin : g_card
    card_model card
    (
      .clk, .sys_rst, .inserted(ins[s]), .batt(batt[s]), .irq_req(irq[s]), .io_mode(iom[s]), .io_read_strobe_n(rd[s]),
      .write_enable_n(we[s]), .card_detect_one(cd1[s]), .card_detect_two(cd2[s]), .batt_detect_one(b1[s]),
      .batt_detect_two(b2[s]), .ready_irq_in(rdy[s]), .input_ack_n(ack[s])
    );
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // wait k edges, then let their updates land
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic conclude;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'h0;
    forever #4 clk = !clk;
  end
  // hang guard, far above the fewer than two hundred cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      conclude();
    end
  end
  initial
  begin
    sys_rst = 1'h1;
    for (int s = 0; s < 2; s++)
    begin
      kind[s] = card_ctl_pkg::cyc_none;
      {attr[s], be[s], bo[s], iom[s], ring[s], irq[s]} = 6'h0;
      ins[s] = 1'h1;
      batt[s] = 2'h3;
    end
    tick(11);
    check({rd[0], wr[0], oe[0], we[0], ce1[0], ce2[0], rg[0], pres[0]}, 8'hfe);
    @(posedge clk);
    sys_rst <= 1'h0;
    foreach (brow[i])
    begin
      @(posedge clk);
      {ins[0], batt[0], iom[0], ring[0]} <= brow[i][12:8];
      tick(5);
      check({2'h0, pres[0], bst[0], ri[0], dst[0]}, brow[i][7:0]);
    end
    @(posedge clk);
    kind[0] <= card_ctl_pkg::cyc_io_read;
    tick(5);
    check({rd[0], wr[0], oe[0], we[0], ce1[0], ce2[0], rg[0], ackd[0]}, 8'hfe);
    @(posedge clk);
    kind[0] <= card_ctl_pkg::cyc_none;
    ins[0] <= 1'h1;
    tick(5);
    foreach (crow[i])
    begin
      @(posedge clk);
      kind[0] <= card_ctl_pkg::cycle_kind_t'(crow[i][13:11]);
      kind[1] <= card_ctl_pkg::cycle_kind_t'(crow[i][13:11]);
      {be[0], bo[0], attr[0]} <= crow[i][10:8];
      {be[1], bo[1], attr[1]} <= crow[i][10:8];
      tick(4);
      check({rd[0], wr[0], oe[0], we[0], ce1[0], ce2[0], rg[0], ackd[0]}, crow[i][7:0]);
      check({rd[1], wr[1], oe[1], we[1], ce1[1], ce2[1], rg[1], ackd[1]}, crow[i][7:0]);
    end
    @(posedge clk);
    kind[0] <= card_ctl_pkg::cyc_mem_write;
    @(posedge clk);
    kind[0] <= card_ctl_pkg::cyc_none;
    tick(5);
    check({7'h0, crdy[0]}, 8'h00);
    tick(12);
    check({6'h0, irqn[0], crdy[0]}, 8'h03);
    @(posedge clk);
    {iom[0], iom[1], irq[0]} <= 3'h7;
    tick(5);
    check({7'h0, irqn[0]}, 8'h00);
    @(posedge clk);
    batt[0] <= 2'h1;
    n = 0;
    repeat (8)
    begin
      tick(1);
      n += int'(alert[0] === 1'h1);
    end
    check(8'(n), 8'h01);
    for (int v = 0; v < 5; v++)
    begin
      @(posedge clk);
      // last step: slot 0 leaves io mode with its speaker high, slot 1 low
      batt[0] <= (v == 4) ? 2'h3 : {1'h1, v[0]};
      batt[1] <= (v == 4) ? 2'h2 : {1'h1, v[1]};
      iom[0]  <= (v != 4);
      tick(5);
      check({7'h0, audio}, (v == 4) ? 8'h00 : {7'h0, v[0] ^ v[1]});
    end
    // reset in mid-run drops a live strobe, then the card is seen again
    @(posedge clk);
    kind[0] <= card_ctl_pkg::cyc_io_read;
    tick(3);
    check({7'h0, rd[0]}, 8'h00);
    @(posedge clk);
    sys_rst <= 1'h1;
    tick(2);
    check({rd[0], wr[0], oe[0], we[0], ce1[0], ce2[0], rg[0], pres[0]}, 8'hfe);
    @(posedge clk);
    sys_rst <= 1'h0;
    kind[0] <= card_ctl_pkg::cyc_none;
    tick(6);
    check({rd[0], wr[0], oe[0], we[0], ce1[0], ce2[0], rg[0], pres[0]}, 8'hff);
    conclude();
  end
endmodule // test_card_socket_control_signals
`default_nettype wire

// *** verilog/card_ctl_pkg.sv ***
`default_nettype none
package card_ctl_pkg;
  // battery condition codes reported to the host side
  typedef enum logic [1:0]
  {
    batt_good,
    batt_weak,
    batt_lost
  } batt_state_t;

  // host cycle kinds requested by the cycle engine
  typedef enum logic [2:0]
  {
    cyc_none,
    cyc_mem_read,
    cyc_mem_write,
    cyc_io_read,
    cyc_io_write
  } cycle_kind_t;

  // socket interface modes
  localparam logic MODE_MEM_ONLY = 1'h0;
  localparam logic MODE_IO       = 1'h1;

  // number of slots served by one instance
  localparam int unsigned SLOT_COUNT = 2;

  // synchroniser depth and reset level of active-low outputs
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic        STROBE_IDLE = 1'h1;
endpackage
`default_nettype wire

// *** verilog/card_socket_control_signals.sv ***
// Contract
// R1: both battery detects high means good
// R2: detect two low, one high: weak
// R3: detect one low: battery dead, data lost
// R4: io mode status-change input flags alert
// R5: ring mode reads status-change as ring
// R6: audio accepted only in io mode
// R7: both slots' audio merged onto one output
// R8: both card detects low means inserted
// R9: first enable even bytes, second odd bytes
// R10: card acks only readable io addresses
// R11: io read strobe during io reads
// R12: io write strobe during io writes
// R13: output enable during memory reads
// R14: memory mode ready low means wait
// R15: io mode ready pin is card irq
// R16: attribute select high only for common memory
// R17: two-flop sync on all card inputs
// R18: no card or reset: strobes high
`timescale 1ns/1ps
`default_nettype none
module card_socket_control_signals
(
  input  wire logic                                        clk,
  input  wire logic                                        sys_rst,
  // per-slot host cycle engine requests
  input  wire card_ctl_pkg::cycle_kind_t                   cycle_kind [card_ctl_pkg::SLOT_COUNT],
  input  wire logic                                        cycle_attr [card_ctl_pkg::SLOT_COUNT],
  input  wire logic                                        byte_even [card_ctl_pkg::SLOT_COUNT],
  input  wire logic                                        byte_odd [card_ctl_pkg::SLOT_COUNT],
  input  wire logic                                        io_mode [card_ctl_pkg::SLOT_COUNT],
  input  wire logic                                        ring_mode [card_ctl_pkg::SLOT_COUNT],
  // per-slot card pins
  input  wire logic                                        card_detect_one [card_ctl_pkg::SLOT_COUNT],
  input  wire logic                                        card_detect_two [card_ctl_pkg::SLOT_COUNT],
  input  wire logic                                        batt_detect_one [card_ctl_pkg::SLOT_COUNT],
  input  wire logic                                        batt_detect_two [card_ctl_pkg::SLOT_COUNT],
  input  wire logic                                        ready_irq_in [card_ctl_pkg::SLOT_COUNT],
  input  wire logic                                        input_ack_n [card_ctl_pkg::SLOT_COUNT],
  output logic                                             even_byte_enable_n [card_ctl_pkg::SLOT_COUNT],
  output logic                                             odd_byte_enable_n [card_ctl_pkg::SLOT_COUNT],
  output logic                                             io_read_strobe_n [card_ctl_pkg::SLOT_COUNT],
  output logic                                             io_write_strobe_n [card_ctl_pkg::SLOT_COUNT],
  output logic                                             output_enable_n [card_ctl_pkg::SLOT_COUNT],
  output logic                                             write_enable_n [card_ctl_pkg::SLOT_COUNT],
  output logic                                             attr_select_n [card_ctl_pkg::SLOT_COUNT],
  // per-slot status to the host side
  output logic                                             card_present [card_ctl_pkg::SLOT_COUNT],
  output logic [1:0]                                       detect_state [card_ctl_pkg::SLOT_COUNT],
  output card_ctl_pkg::batt_state_t                        batt_state [card_ctl_pkg::SLOT_COUNT],
  output logic                                             status_change_alert [card_ctl_pkg::SLOT_COUNT],
  output logic                                             ring_indicate_in [card_ctl_pkg::SLOT_COUNT],
  output logic                                             card_ready [card_ctl_pkg::SLOT_COUNT],
  output logic                                             card_irq_n [card_ctl_pkg::SLOT_COUNT],
  output logic                                             io_read_acked [card_ctl_pkg::SLOT_COUNT],
  // combined speaker output
  output logic                                             combined_audio_out
);

  // decodes the battery pair into a condition code
  // a dead battery wins over a weak one, whatever detect two reads
  function automatic card_ctl_pkg::batt_state_t batt_decode(input logic one, input logic two);
    // R3: detect one low wins
    if (!one)
      batt_decode = card_ctl_pkg::batt_lost;
    // R2: weak battery
    else if (!two)
      batt_decode = card_ctl_pkg::batt_weak;
    // R1: good battery
    else
      batt_decode = card_ctl_pkg::batt_good;
  endfunction

  // merged audio for the output flop
  logic nxt_audio;
  logic audio_ok [card_ctl_pkg::SLOT_COUNT];

  genvar s;
  generate
    for (s = 0; s < card_ctl_pkg::SLOT_COUNT; s = s + 1)
    begin : g_slot
      // raw pin bundle: cd1, cd2, batt_detect_one, batt_detect_two, ready, input_ack_n
      logic [5:0] sync1_ff;
      logic [5:0] sync2_ff;
      logic [5:0] raw_pins;
      // presence is registered, and the strobes gated by it follow
      // the card_present output one cycle later
      logic       nxt_present;
      logic       present_ff;
      logic       stat_prev_ff;
      logic       nxt_stat_prev;
      // status outputs computed off the synced pins
      card_ctl_pkg::batt_state_t nxt_batt;
      logic       nxt_ready;
      logic       nxt_irq;
      logic       nxt_acked;
      logic       ready_ff;
      logic       irq_ff;
      logic       acked_ff;
      // registered outputs and their next values
      logic nxt_ce_even;
      logic nxt_ce_odd;
      logic nxt_io_read_strobe_n;
      logic nxt_io_write_strobe_n;
      logic nxt_oe;
      logic nxt_we;
      logic nxt_reg;
      logic nxt_alert;
      logic nxt_ring;
      logic ce_even_ff;
      logic ce_odd_ff;
      logic io_read_strobe_n_ff;
      logic io_write_strobe_n_ff;
      logic oe_ff;
      logic we_ff;
      logic reg_ff;
      logic alert_ff;
      logic ring_ff;
      card_ctl_pkg::batt_state_t batt_ff;

      assign raw_pins = {card_detect_one[s], card_detect_two[s], batt_detect_one[s],
                         batt_detect_two[s], ready_irq_in[s], input_ack_n[s]};

      // R17: two-flop sync
      // a card may be pulled at any moment, so every pin is asynchronous;
      // resetting to ones reads as no card and no acknowledge
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          sync1_ff <= 6'h3f;
          sync2_ff <= 6'h3f;
        end
        else
        begin
          sync1_ff <= raw_pins;
          sync2_ff <= sync1_ff;
        end
      end

      // strobe and status next-state logic; the case below only runs
      // with a card present, so a pulled card drops every strobe at once
      always_comb
      begin
        // R8: both detects low
        nxt_present   = !sync2_ff[5] && !sync2_ff[4];
        // R1: good, weak or lost from the synced pair
        nxt_batt      = batt_decode(sync2_ff[3], sync2_ff[2]);
        // R14: memory mode ready level
        nxt_ready     = (io_mode[s] == card_ctl_pkg::MODE_MEM_ONLY) ? sync2_ff[1] : 1'h0;
        // R15: io mode irq pin
        nxt_irq       = (io_mode[s] == card_ctl_pkg::MODE_IO) ? sync2_ff[1] : 1'h1;
        // R10: ack during our read
        nxt_acked     = !sync2_ff[0] && !io_read_strobe_n_ff;
        nxt_ce_even   = card_ctl_pkg::STROBE_IDLE;
        nxt_ce_odd    = card_ctl_pkg::STROBE_IDLE;
        nxt_io_read_strobe_n      = card_ctl_pkg::STROBE_IDLE;
        nxt_io_write_strobe_n      = card_ctl_pkg::STROBE_IDLE;
        nxt_oe        = card_ctl_pkg::STROBE_IDLE;
        nxt_we        = card_ctl_pkg::STROBE_IDLE;
        nxt_reg       = card_ctl_pkg::STROBE_IDLE;
        nxt_stat_prev = sync2_ff[3];
        nxt_alert     = 1'h0;
        nxt_ring      = 1'h0;
        // R18: strobes idle without a card
        if (present_ff && cycle_kind[s] != card_ctl_pkg::cyc_none)
        begin
          // R9: even/odd byte enables
          nxt_ce_even = !byte_even[s];
          nxt_ce_odd  = !byte_odd[s];
          case (cycle_kind[s])
            // R13: output enable for memory reads
            card_ctl_pkg::cyc_mem_read:
            begin
              nxt_oe  = 1'h0;
              nxt_reg = !cycle_attr[s];
            end
            card_ctl_pkg::cyc_mem_write:
            begin
              nxt_we  = 1'h0;
              nxt_reg = !cycle_attr[s];
            end
            // R11: io read strobe
            card_ctl_pkg::cyc_io_read:
            begin
              nxt_io_read_strobe_n = 1'h0;
              // R16: attribute select for io space
              nxt_reg  = 1'h0;
            end
            // R12: io write strobe
            card_ctl_pkg::cyc_io_write:
            begin
              nxt_io_write_strobe_n = 1'h0;
              nxt_reg  = 1'h0;
            end
            default:
            begin
              nxt_ce_even = card_ctl_pkg::STROBE_IDLE;
              nxt_ce_odd  = card_ctl_pkg::STROBE_IDLE;
            end
          endcase
        end
        // shared pin: ring, or alert on an asserted (low) edge
        // the previous-level flop resets high; the falling edge that a low pin shows after reset release
        // is masked because present_ff rises a cycle later, so reset release never fakes an alert
        if (present_ff && io_mode[s] == card_ctl_pkg::MODE_IO)
        begin
          // R5: ring detect reading
          if (ring_mode[s])
            nxt_ring = !sync2_ff[3];
          // R4: status-change alert
          else
            nxt_alert = stat_prev_ff && !sync2_ff[3];
        end
      end

      // registers for this slot; idle values under reset
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          ce_even_ff   <= card_ctl_pkg::STROBE_IDLE;
          ce_odd_ff    <= card_ctl_pkg::STROBE_IDLE;
          io_read_strobe_n_ff      <= card_ctl_pkg::STROBE_IDLE;
          io_write_strobe_n_ff      <= card_ctl_pkg::STROBE_IDLE;
          oe_ff        <= card_ctl_pkg::STROBE_IDLE;
          we_ff        <= card_ctl_pkg::STROBE_IDLE;
          reg_ff       <= card_ctl_pkg::STROBE_IDLE;
          stat_prev_ff <= 1'h1;
          alert_ff     <= 1'h0;
          ring_ff      <= 1'h0;
          batt_ff      <= card_ctl_pkg::batt_good;
          // no card and no interrupt request until the pins are seen
          present_ff   <= 1'h0;
          ready_ff     <= 1'h0;
          irq_ff       <= 1'h1;
          acked_ff     <= 1'h0;
        end
        else
        begin
          ce_even_ff   <= nxt_ce_even;
          ce_odd_ff    <= nxt_ce_odd;
          io_read_strobe_n_ff      <= nxt_io_read_strobe_n;
          io_write_strobe_n_ff      <= nxt_io_write_strobe_n;
          oe_ff        <= nxt_oe;
          we_ff        <= nxt_we;
          reg_ff       <= nxt_reg;
          stat_prev_ff <= nxt_stat_prev;
          alert_ff     <= nxt_alert;
          ring_ff      <= nxt_ring;
          batt_ff      <= nxt_batt;
          present_ff   <= nxt_present;
          ready_ff     <= nxt_ready;
          irq_ff       <= nxt_irq;
          acked_ff     <= nxt_acked;
        end
      end

      // every output below is a flop, so the host side never sees a
      // combinational glitch from the card pins or the mode inputs
      assign even_byte_enable_n[s]  = ce_even_ff;
      assign odd_byte_enable_n[s]   = ce_odd_ff;
      assign io_read_strobe_n[s]    = io_read_strobe_n_ff;
      assign io_write_strobe_n[s]   = io_write_strobe_n_ff;
      assign output_enable_n[s]     = oe_ff;
      assign write_enable_n[s]      = we_ff;
      assign attr_select_n[s]       = reg_ff;
      assign card_present[s]        = present_ff;
      assign detect_state[s]        = sync2_ff[5:4];
      assign batt_state[s]          = batt_ff;
      assign status_change_alert[s] = alert_ff;
      assign ring_indicate_in[s]    = ring_ff;
      assign card_ready[s]          = ready_ff;
      assign card_irq_n[s]          = irq_ff;
      assign io_read_acked[s]       = acked_ff;
      // R6: audio only in io mode
      // limitation: io_mode is not synchronised, it must come from the clk domain
      assign audio_ok[s]            = present_ff && io_mode[s] == card_ctl_pkg::MODE_IO && sync2_ff[2];
    end
  endgenerate

  // R7: exclusive-or mix of both slots
  // trade-off: exclusive-or keeps two tones audible as a beat, where an or
  // would let one slot's steady high mask the other
  always_comb
  begin
    nxt_audio = audio_ok[0] ^ audio_ok[1];
  end

  // audio output flop
  // registered so the speaker pin comes straight from a flop
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      combined_audio_out <= 1'h0;
    else
      combined_audio_out <= nxt_audio;
  end

endmodule // card_socket_control_signals
`default_nettype wire
